// *** src/config_control_status_pins.sv ***
// Purpose: Control and status handshake pins of a configuration engine
// Assumes: Data path reports image_received_i and image_error_i as pulses
// Notes: Open-drain pins are drive-low enables plus sampled wire levels
// Function
// - Request low in user mode resets, tristates
// - Request returning high starts fresh configuration once chip enable is low
// - Status low after power-up until configuration starts
// - Configuration error pulls status low
// - External status low during configuration means error
// - Status transitions ignored in user mode
// - Load-complete held low until data taken
// - Release load-complete after error-free image
// - Initialize on data received and line high
// - External low on load-complete ignored afterwards
// - Chain-enable output low once configured
// - Active serial: select enables serial memory
// - Active parallel: select enables parallel flash
`timescale 1ns/10ps
`default_nettype none
`include "cfg_ctrl_cfg.svh"

module config_control_status_pins
  import cfg_ctrl_pkg::*;
#(
  parameter int POR_CYCLES = `POR_CYCLES,
  parameter int INIT_CYCLES = `INIT_CYCLES
)
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // Pin-side control inputs
  input wire logic [1:0] scheme_select_i,
  input wire logic config_request_n_i,
  input wire logic chip_enable_n_i,
  // Open-drain status line: sampled level and pull-low enable
  input wire logic status_n_i,
  output logic status_n_o,
  output logic status_n_oe_o,
  // Open-drain load-complete line
  input wire logic load_complete_i,
  output logic load_complete_o,
  output logic load_complete_oe_o,
  // Open-drain chain enable to next device
  output logic chain_enable_out_n_o,
  output logic chain_enable_out_n_oe_o,
  // External configuration memory select, active low
  output logic memory_select_n_o,
  // Data path handshake, same clock domain
  input wire logic image_received_i,
  input wire logic image_error_i,
  output logic config_active_o,
  // Device state seen by the core
  output logic user_mode_o,
  output logic user_io_tristate_o,
  output logic core_reset_o
);

  // Edges before a low status level in configuration can be trusted
  localparam int SETTLE_CYCLES = `STATUS_SETTLE_CYCLES;
  localparam int CNT_MAX = (POR_CYCLES > INIT_CYCLES) ? POR_CYCLES : INIT_CYCLES;
  localparam int CNT_W = $clog2(((CNT_MAX > SETTLE_CYCLES) ? CNT_MAX : SETTLE_CYCLES) + 1);

  // Whole state of the block as one record
  typedef struct packed {
    cfg_state_type state;
    logic [CNT_W-1:0] count;
    logic [1:0] scheme;
    logic [2:0][1:0] sel_sync;
    logic [1:0] sel_lvl;
    logic [2:0] req_sync;
    logic [2:0] stat_sync;
    logic [2:0] done_sync;
    logic [2:0] ce_sync;
    logic req_lvl;
    logic stat_lvl;
    logic done_lvl;
    logic ce_lvl;
    logic got_image;
  } regs_type;

  regs_type r_reg;
  regs_type r_next;
  logic active_scheme;
  logic status_settled;

  // Our own pull-down of the status line takes a few edges to leave the filter
  assign status_settled = (r_reg.count == CNT_W'(SETTLE_CYCLES));

  // Select output only matters for the two active schemes
  assign active_scheme = (r_reg.scheme == `SCHEME_ACTIVE_SERIAL) ||
                         (r_reg.scheme == `SCHEME_ACTIVE_PARALLEL);

  // Next-state logic: synchronisers, filters and the sequencer
  always_comb
  begin
    r_next = r_reg;
    // Three-stage synchronisers; only the last two stages are compared
    r_next.req_sync = {r_reg.req_sync[1:0], config_request_n_i};
    r_next.stat_sync = {r_reg.stat_sync[1:0], status_n_i};
    r_next.done_sync = {r_reg.done_sync[1:0], load_complete_i};
    r_next.ce_sync = {r_reg.ce_sync[1:0], chip_enable_n_i};
    r_next.sel_sync = {r_reg.sel_sync[1:0], scheme_select_i};
    if (r_reg.req_sync[2] == r_reg.req_sync[1])
    begin
      r_next.req_lvl = r_reg.req_sync[2];
    end
    if (r_reg.stat_sync[2] == r_reg.stat_sync[1])
    begin
      r_next.stat_lvl = r_reg.stat_sync[2];
    end
    if (r_reg.done_sync[2] == r_reg.done_sync[1])
    begin
      r_next.done_lvl = r_reg.done_sync[2];
    end
    if (r_reg.ce_sync[2] == r_reg.ce_sync[1])
    begin
      r_next.ce_lvl = r_reg.ce_sync[2];
    end
    // Scheme pins are static, but still pass the same filter
    if (r_reg.sel_sync[2] == r_reg.sel_sync[1])
    begin
      r_next.sel_lvl = r_reg.sel_sync[2];
    end

    // A low request overrides every state after power-on
    if (r_reg.state != ST_POR && !r_reg.req_lvl)
    begin
      r_next.state = ST_RESET;
      r_next.got_image = 1'b0;
    end
    else
    begin
      unique case (r_reg.state)
        // Hold status low for the power-on interval
        ST_POR:
        begin
          if (r_reg.count == CNT_W'(POR_CYCLES - 1))
          begin
            r_next.count = '0;
            r_next.state = ST_RESET;
          end
          else
          begin
            r_next.count = r_reg.count + 1'b1;
          end
        end
        // Request is high again: start over once enabled
        ST_RESET:
        begin
          r_next.got_image = 1'b0;
          if (!r_reg.ce_lvl)
          begin
            r_next.scheme = r_reg.sel_lvl;
            r_next.count = '0;
            r_next.state = ST_CONFIG;
          end
        end
        // Take in the image; watch for faults
        ST_CONFIG:
        begin
          // The filter still shows our own pull-down for a few edges after release
          if (!status_settled)
          begin
            r_next.count = r_reg.count + 1'b1;
          end
          if (image_error_i || (status_settled && !r_reg.stat_lvl))
          begin
            r_next.state = ST_ERROR;
          end
          else if (image_received_i || r_reg.got_image)
          begin
            r_next.got_image = 1'b1;
            // Wired line must actually read high before initializing
            if (r_reg.done_lvl && status_settled)
            begin
              r_next.count = '0;
              r_next.state = ST_INIT;
            end
          end
        end
        // Initialization cycle, still sensitive to an external status low
        ST_INIT:
        begin
          if (!r_reg.stat_lvl)
          begin
            r_next.state = ST_ERROR;
          end
          else if (r_reg.count == CNT_W'(INIT_CYCLES - 1))
          begin
            r_next.state = ST_USER;
          end
          else
          begin
            r_next.count = r_reg.count + 1'b1;
          end
        end
        // Configured: status and load-complete lines are not looked at
        ST_USER:
        begin
          r_next.state = ST_USER;
        end
        // Stay failed until the host pulses the request low
        ST_ERROR:
        begin
          r_next.state = ST_ERROR;
        end
        default:
        begin
          r_next.state = ST_RESET;
        end
      endcase
    end
  end

  // State register; constants only under reset
  always_ff @(posedge ref_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      r_reg <= '{state: ST_POR, count: '0, scheme: 2'h0, sel_sync: '0, sel_lvl: 2'h0,
                 req_sync: 3'h7, stat_sync: 3'h7,
                 done_sync: 3'h0, ce_sync: 3'h7, req_lvl: 1'b1, stat_lvl: 1'b1,
                 done_lvl: 1'b0, ce_lvl: 1'b1, got_image: 1'b0};
    end
    else
    begin
      r_reg <= r_next;
    end
  end

  // Open-drain outputs always drive zero; only the enables move
  assign status_n_o = 1'b0;
  assign load_complete_o = 1'b0;
  assign chain_enable_out_n_o = 1'b0;
  // Status pulled low during power-on, reset and after a fault
  assign status_n_oe_o = (r_reg.state == ST_POR) || (r_reg.state == ST_RESET) ||
                         (r_reg.state == ST_ERROR);
  // Load-complete held low until the image is in
  assign load_complete_oe_o = (r_reg.state == ST_POR) || (r_reg.state == ST_RESET) ||
                              (r_reg.state == ST_ERROR) ||
                              ((r_reg.state == ST_CONFIG) && !r_reg.got_image);
  // Next device enabled once this one is configured
  assign chain_enable_out_n_oe_o = (r_reg.state == ST_USER);
  // Memory select low while reading an active scheme image
  assign memory_select_n_o = !((r_reg.state == ST_CONFIG) && !r_reg.got_image &&
                               active_scheme);
  assign config_active_o = (r_reg.state == ST_CONFIG) && !r_reg.got_image;
  assign user_mode_o = (r_reg.state == ST_USER);
  assign user_io_tristate_o = (r_reg.state != ST_USER);
  assign core_reset_o = (r_reg.state == ST_POR) || (r_reg.state == ST_RESET);

endmodule // config_control_status_pins

`default_nettype wire

// *** src/cfg_ctrl_cfg.svh ***
// Purpose: Constants for the configuration control and status pin block
// Assumes: 10 MHz reference clock
// Notes: Scheme encodings and timing counts live here as macros
`ifndef CFG_CTRL_CFG_SVH
`define CFG_CTRL_CFG_SVH

// Scheme select codes on the two-bit select input
`define SCHEME_PASSIVE_SERIAL 2'h0
`define SCHEME_FAST_PASSIVE_PARALLEL 2'h1
`define SCHEME_ACTIVE_SERIAL 2'h2
`define SCHEME_ACTIVE_PARALLEL 2'h3

// Power-on reset interval in microseconds and its cycle count at 100 ns
`define POR_TIME_US 100
`define CLK_PERIOD_NS 100
`define POR_CYCLES ((`POR_TIME_US * 1000) / `CLK_PERIOD_NS)

// Initialization cycle length in clock cycles
`define INIT_CYCLES 16

// Edges for our own status release to pass the pin synchroniser and filter
`define STATUS_SETTLE_CYCLES 4

`endif

// *** src/cfg_ctrl_pkg.sv ***
// Purpose: Types for the configuration control and status pin block
// Assumes: Nothing beyond the constants header
// Notes: Holds the state enumeration only
package cfg_ctrl_pkg;

  // Configuration engine states
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_RESET = 3'h1,
    ST_CONFIG = 3'h2,
    ST_INIT = 3'h3,
    ST_USER = 3'h4,
    ST_ERROR = 3'h5
  } cfg_state_type;

endpackage

// *** sim/cfg_pins_assertions.sv ***
// Purpose: Port-level checks for the configuration control pin block
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: Pin filter latency is a few edges, so windows allow slack
`timescale 1ns/10ps
`default_nettype none
module cfg_pins_assertions (
  // Clock, reset and pin inputs
  input wire logic ref_clk_i, reset_n_i, config_request_n_i, status_n_i,
  input wire logic image_error_i, load_complete_i,
  input wire logic [1:0] scheme_select_i,
  // Observed outputs
  input wire logic status_n_oe_o, load_complete_oe_o, chain_enable_out_n_oe_o,
  input wire logic memory_select_n_o, config_active_o, user_mode_o,
  input wire logic user_io_tristate_o, core_reset_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  // Long enough for the input synchroniser and filter to settle
  sequence req_held_low; !config_request_n_i [*8]; endsequence
  sequence req_high_user; (config_request_n_i && user_mode_o) [*8]; endsequence
  sequence ext_status_low; (config_active_o && !status_n_i && !status_n_oe_o) [*4]; endsequence
  AST_REQ_LOW_RESETS: assert property (req_held_low |-> user_io_tristate_o && !user_mode_o)
    else $error("request held low but device not reset");
  AST_POR_PULLS_LOW: assert property (core_reset_o |-> status_n_oe_o && load_complete_oe_o)
    else $error("status or load line released during reset");
  AST_ERROR_FLAGGED: assert property (config_active_o && image_error_i |-> ##[1:3] status_n_oe_o)
    else $error("image error did not pull status low");
  AST_EXT_STATUS_ERR: assert property (ext_status_low |-> ##[0:4] status_n_oe_o)
    else $error("external status low did not raise error");
  AST_USER_STEADY: assert property (req_high_user |=> user_mode_o)
    else $error("user mode left without request");
  AST_USER_OUTPUTS: assert property (chain_enable_out_n_oe_o == user_mode_o && user_io_tristate_o == !user_mode_o)
    else $error("chain enable or tristate disagrees with user mode");
  AST_LOAD_HELD: assert property (config_active_o |-> load_complete_oe_o && memory_select_n_o == (scheme_select_i < 2'h2))
    else $error("load line or memory select wrong while loading");
  AST_MEM_ONLY_LOAD: assert property (!memory_select_n_o |-> config_active_o)
    else $error("memory selected outside loading");
  AST_USER_ENTRY: assert property ($rose(user_mode_o) |-> $past(load_complete_i, 2) && !load_complete_oe_o)
    else $error("user mode entered without load line high");
endmodule // cfg_pins_assertions
bind config_control_status_pins cfg_pins_assertions i_cfg_pins_assertions (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .config_request_n_i(config_request_n_i),
  .status_n_i(status_n_i), .image_error_i(image_error_i), .load_complete_i(load_complete_i),
  .scheme_select_i(scheme_select_i), .status_n_oe_o(status_n_oe_o),
  .load_complete_oe_o(load_complete_oe_o), .chain_enable_out_n_oe_o(chain_enable_out_n_oe_o),
  .memory_select_n_o(memory_select_n_o), .config_active_o(config_active_o),
  .user_mode_o(user_mode_o), .user_io_tristate_o(user_io_tristate_o), .core_reset_o(core_reset_o));
`default_nettype wire

// *** sim/cfg_host_model.sv ***
// Purpose: Board side of the open-drain status and load-complete lines
// Assumes: External pull-ups on both lines
// Notes: Host can hold either line low to provoke faults
`timescale 1ns/10ps
`default_nettype none
module cfg_host_model (
  // Enables and driven values of the device, then the host's own pulls
  input wire logic status_oe_i,
  input wire logic status_val_i,
  input wire logic load_oe_i,
  input wire logic load_val_i,
  input wire logic hold_status_low_i,
  input wire logic hold_load_low_i,
  // Wired-AND levels back to the device
  output logic status_line_o,
  output logic load_line_o
);
  // Released lines float up through the pull-ups; any driver wins low
  assign status_line_o = !hold_status_low_i && (!status_oe_i || status_val_i);
  assign load_line_o = !hold_load_low_i && (!load_oe_i || load_val_i);
endmodule // cfg_host_model
`default_nettype wire

// *** sim/testbench.sv ***
// Purpose: Self-checking bench for the configuration control pins
// Assumes: Short POR and init counts set through parameters
// Notes: Outputs are compared as one packed status vector
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import cfg_ctrl_pkg::*;
  logic ref_clk_i = 0, reset_n_i = 0, req_n = 1, ce_n = 0, img = 0, err = 0;
  logic st_low = 0, ld_low = 0;
  logic [1:0] sel = 2'h0;
  wire logic st_w, ld_w, st_oe, ld_oe, ch_oe, ms_n, act, um, tri_o, crst;
  wire logic st_o, ld_o, ch_o;
  wire logic [7:0] vec = {st_oe, ld_oe, ch_oe, ms_n, act, um, tri_o, crst};
  int bad_count = 0, n_tests = 0, k;
  integer seed = 53580;
  always #50 ref_clk_i = ~ref_clk_i;
  config_control_status_pins #(.POR_CYCLES(8), .INIT_CYCLES(4)) i_config_control_status_pins (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .scheme_select_i(sel),
    .config_request_n_i(req_n), .chip_enable_n_i(ce_n), .status_n_i(st_w), .status_n_o(st_o),
    .status_n_oe_o(st_oe), .load_complete_i(ld_w), .load_complete_o(ld_o),
    .load_complete_oe_o(ld_oe), .chain_enable_out_n_o(ch_o), .chain_enable_out_n_oe_o(ch_oe),
    .memory_select_n_o(ms_n), .image_received_i(img), .image_error_i(err),
    .config_active_o(act), .user_mode_o(um), .user_io_tristate_o(tri_o), .core_reset_o(crst));
  cfg_host_model i_cfg_host_model (.status_oe_i(st_oe), .status_val_i(st_o),
    .load_oe_i(ld_oe), .load_val_i(ld_o),
    .hold_status_low_i(st_low), .hold_load_low_i(ld_low), .status_line_o(st_w),
    .load_line_o(ld_w));
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
    #10;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // Bounded wait for the pins to reach a state, then compare
  task automatic expect_vec(input logic [7:0] exp);
    for (k = 0; k < 40 && vec !== exp; k++) cyc(1);
    chk(vec, exp);
  endtask
  task automatic finish_test;
    $display("compares %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    cyc(10);
    reset_n_i = 1;
    chk(vec, 8'hD3);
    for (int s = 0; s < 4; s++)
    begin
      sel = s[1:0];
      req_n = 0;
      expect_vec(8'hD3);
      req_n = 1;
      expect_vec((s < 2) ? 8'h5A : 8'h4A);
      cyc(1 + ($random(seed) & 7));
      chk(vec, (s < 2) ? 8'h5A : 8'h4A);
      ld_low = 1;
      img = 1;
      cyc(1);
      img = 0;
      expect_vec(8'h12);
      cyc(10);
      chk(vec, 8'h12);
      ld_low = 0;
      expect_vec(8'h34);
      chk({5'h00, st_o, ld_o, ch_o}, 8'h00);
      st_low = 1;
      ld_low = 1;
      cyc(10);
      chk(vec, 8'h34);
      st_low = 0;
      ld_low = 0;
    end
    err = 1;
    req_n = 0;
    expect_vec(8'hD3);
    req_n = 1;
    expect_vec(8'h4A);
    cyc(1);
    err = 0;
    cyc(6);
    chk({5'h00, st_oe, um, act}, 8'h04);
    ce_n = 1;
    req_n = 0;
    expect_vec(8'hD3);
    req_n = 1;
    cyc(10);
    chk(vec, 8'hD3);
    ce_n = 0;
    expect_vec(8'h4A);
    st_low = 1;
    cyc(10);
    chk({5'h00, st_oe, um, act}, 8'h04);
    st_low = 0;
    finish_test;
  end
  // Whole run is well under a thousand cycles
  initial
  begin
    #500000;
    bad_count++;
    finish_test;
  end
endmodule // testbench
`default_nettype wire
